/* verilog/fspa_top.sv */
`timescale 1ns/1ps
`include "fspa_cfg.svh"
module fspa_top
  import fspa_pkg::*;
#(
  parameter logic [16:0] FLASH_BYTES = 17'h0F000
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire fspa_mode_e i_mode,
  input  wire logic       i_tool_attached,
  input  wire logic       i_req_valid,
  input  wire fspa_req_s  i_req,
  input  wire logic [7:0] i_option,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_app_sclk_o,
  input  wire logic       i_app_sdata_o,
  input  wire logic       i_app_sdata_oe,
  input  wire logic       i_link_sdata_o,
  input  wire logic       i_link_sdata_oe,
  output logic            o_cmd_valid,
  output fspa_cmd_s       o_cmd,
  output logic            o_rejected,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  output logic            o_readout_protect,
  output logic            o_auto_erase_busy,
  output logic            o_pins_taken,
  output logic            o_sclk_o,
  output logic            o_sdata_o,
  output logic            o_sdata_oe
);
  typedef struct packed {
    logic       cmd_valid;
    fspa_cmd_s  cmd;
    logic       rejected;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       rop;
    logic       busy;
    logic [1:0] cnt;
    logic [7:0] pend_opt;
    logic       taken;
    logic       sclk;
    logic       sdo;
    logic       sdoe;
  } fspa_state_s;

  fspa_state_s s_q;
  fspa_state_s s_d;
  logic        a_valid;
  logic [1:0]  a_sector;
  logic        ext_mode;
  logic        allowed;

  fspa_sector_map #(
    .FLASH_BYTES (FLASH_BYTES)
  ) u_map (
    .i_addr   (i_req.addr),
    .o_valid  (a_valid),
    .o_sector (a_sector)
  );

  function automatic logic sector_ok(input fspa_mode_e m, input logic [1:0] sec);
    sector_ok = 1'b0;
    case (m)
      FSPA_MODE_IN_APPLICATION_PROGRAMMING: sector_ok = (sec != 2'h0);
      FSPA_MODE_INCIRCUIT_PROGRAMMING: sector_ok = 1'b1;
      FSPA_MODE_TOOL: sector_ok = 1'b1;
      default: sector_ok = 1'b0;
    endcase
  endfunction

  assign ext_mode = (i_mode == FSPA_MODE_INCIRCUIT_PROGRAMMING) || (i_mode == FSPA_MODE_TOOL);

  always_comb begin
    allowed = 1'b0;
    case (i_req.op)
      FSPA_OP_MASS_ERASE: allowed = ext_mode;
      FSPA_OP_PROG, FSPA_OP_SECT_ERASE: begin
        if (i_req.opt) begin
          allowed = ext_mode && (i_req.op == FSPA_OP_PROG);
        end else begin
          allowed = a_valid && sector_ok(i_mode, a_sector) && !s_q.rop;
        end
      end
      default: allowed = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.cmd_valid = 1'b0;
    s_d.cmd = '0;
    s_d.rejected = 1'b0;
    s_d.rd_valid = i_rd_valid;
    s_d.rd_data = s_q.rop ? 8'h00 : i_rd_data;
    s_d.rop = i_option[`FSPA_OPT_ROP_BIT];
    s_d.taken = i_tool_attached;
    s_d.sclk = i_tool_attached ? 1'b0 : i_app_sclk_o;
    s_d.sdo = i_tool_attached ? i_link_sdata_o : i_app_sdata_o;
    s_d.sdoe = i_tool_attached ? i_link_sdata_oe : i_app_sdata_oe;
    // Unprotecting sweeps every sector through erase; the option byte is rewritten with the last (sector 2) erase.
    if (s_q.busy) begin
      s_d.cmd_valid = 1'b1;
      s_d.cmd.erase = 1'b1;
      s_d.cmd.sector = s_q.cnt;
      if (s_q.cnt == 2'h2) begin
        s_d.busy = 1'b0;
        s_d.cnt = 2'h0;
        s_d.cmd.opt_we = 1'b1;
        s_d.cmd.opt_data = s_q.pend_opt;
        s_d.cmd.mass = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 2'h1;
      end
      if (i_req_valid) begin
        s_d.rejected = 1'b1;
      end
    end else if (i_req_valid) begin
      if (!allowed) begin
        s_d.rejected = 1'b1;
      end else if (i_req.opt && s_q.rop && !i_req.data[`FSPA_OPT_ROP_BIT]) begin
        s_d.busy = 1'b1;
        s_d.cnt = 2'h0;
        s_d.pend_opt = i_req.data;
      end else begin
        s_d.cmd_valid = 1'b1;
        s_d.cmd.addr = i_req.addr;
        s_d.cmd.data = i_req.data;
        s_d.cmd.we = (i_req.op == FSPA_OP_PROG) && !i_req.opt;
        s_d.cmd.erase = (i_req.op != FSPA_OP_PROG);
        s_d.cmd.mass = (i_req.op == FSPA_OP_MASS_ERASE);
        s_d.cmd.sector = a_sector;
        s_d.cmd.opt_we = i_req.opt;
        s_d.cmd.opt_data = i_req.data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_cmd_valid = s_q.cmd_valid;
  assign o_cmd = s_q.cmd;
  assign o_rejected = s_q.rejected;
  assign o_rd_valid = s_q.rd_valid;
  assign o_rd_data = s_q.rd_data;
  assign o_readout_protect = s_q.rop;
  assign o_auto_erase_busy = s_q.busy;
  assign o_pins_taken = s_q.taken;
  assign o_sclk_o = s_q.sclk;
  assign o_sdata_o = s_q.sdo;
  assign o_sdata_oe = s_q.sdoe;

  property p_app_sec0;
    @(posedge i_clk) disable iff (i_srst)
      (i_req_valid && !s_q.busy && i_mode == FSPA_MODE_IN_APPLICATION_PROGRAMMING &&
       !i_req.opt && i_req.op != FSPA_OP_NONE && i_req.addr >= `FSPA_SEC0_BASE) |=>
        o_rejected;
  endproperty
  a_app_sec0: assert property (p_app_sec0) else $error("Sector zero touched.");

  property p_rop_block;
    @(posedge i_clk) disable iff (i_srst)
      (i_req_valid && !s_q.busy && s_q.rop && !i_req.opt &&
       i_req.op != FSPA_OP_MASS_ERASE) |=> (o_rejected && !o_cmd.we);
  endproperty
  a_rop_block: assert property (p_rop_block) else $error("Write passed under protection.");

  property p_rop_read;
    @(posedge i_clk) disable iff (i_srst)
      (s_q.rop && i_rd_valid) |=> (o_rd_data == 8'h00);
  endproperty
  a_rop_read: assert property (p_rop_read) else $error("Read leaked under protection.");

  property p_auto_erase;
    @(posedge i_clk) disable iff (i_srst)
      $rose(o_auto_erase_busy) |-> ##[1:4] (o_cmd_valid && o_cmd.mass && o_cmd.opt_we);
  endproperty
  a_auto_erase: assert property (p_auto_erase) else $error("Auto erase did not finish.");

  property p_rop_opt;
    @(posedge i_clk) disable iff (i_srst)
      ##1 (o_readout_protect == $past(i_option[`FSPA_OPT_ROP_BIT]));
  endproperty
  a_rop_opt: assert property (p_rop_opt) else $error("Protection not from option.");

  property p_pins;
    @(posedge i_clk) disable iff (i_srst)
      i_tool_attached |=> (o_pins_taken && !o_sclk_o && o_sdata_oe == $past(i_link_sdata_oe));
  endproperty
  a_pins: assert property (p_pins) else $error("Application kept serial pins.");

  property p_ignore;
    @(posedge i_clk) disable iff (i_srst)
      o_rejected |-> !(o_cmd_valid && !o_auto_erase_busy && !$past(o_auto_erase_busy));
  endproperty
  a_ignore: assert property (p_ignore) else $error("Rejected request issued.");

  property p_ext_all;
    @(posedge i_clk) disable iff (i_srst)
      (i_req_valid && !s_q.busy && ext_mode && !s_q.rop && !i_req.opt && a_valid &&
       i_req.op == FSPA_OP_SECT_ERASE) |=> (o_cmd_valid && o_cmd.erase && !o_cmd.we);
  endproperty
  a_ext_all: assert property (p_ext_all) else $error("Tool erase refused.");

  property p_busy_reject;
    @(posedge i_clk) disable iff (i_srst)
      (s_q.busy && i_req_valid) |=> (o_rejected && !o_cmd.we);
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("Busy request taken.");

  c_prog: cover property (@(posedge i_clk) o_cmd_valid && o_cmd.we);
  c_rej: cover property (@(posedge i_clk) o_rejected);
  c_auto: cover property (@(posedge i_clk) $fell(o_auto_erase_busy));
  c_busy_rej: cover property (@(posedge i_clk) s_q.busy && i_req_valid);
  c_opt: cover property (@(posedge i_clk) o_cmd_valid && o_cmd.opt_we);
endmodule

/* verilog/fspa_cfg.svh */
`ifndef FSPA_CFG_SVH
`define FSPA_CFG_SVH
`define FSPA_ADDR_W      16
`define FSPA_SEC0_BASE   16'hF000
`define FSPA_SEC1_BASE   16'hE000
`define FSPA_SEC_BYTES   17'h01000
`define FSPA_SIZE_4K     17'h01000
`define FSPA_SIZE_8K     17'h02000
`define FSPA_OPT_ROP_BIT 0
`define FSPA_OPT_RESET   8'h00
`define FSPA_ERASE_NS    10
`define FSPA_CLK_NS      10
`define FSPA_ERASE_CYC   ((`FSPA_ERASE_NS + `FSPA_CLK_NS - 1) / `FSPA_CLK_NS)
`endif

/* verilog/fspa_pkg.sv */
package fspa_pkg;
  typedef enum logic [1:0] {
    FSPA_MODE_APP,
    FSPA_MODE_IN_APPLICATION_PROGRAMMING,
    FSPA_MODE_INCIRCUIT_PROGRAMMING,
    FSPA_MODE_TOOL
  } fspa_mode_e;

  typedef enum logic [1:0] {
    FSPA_OP_NONE,
    FSPA_OP_PROG,
    FSPA_OP_SECT_ERASE,
    FSPA_OP_MASS_ERASE
  } fspa_op_e;

  typedef struct packed {
    fspa_op_e    op;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        opt;
  } fspa_req_s;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        erase;
    logic [1:0]  sector;
    logic        mass;
    logic        opt_we;
    logic [7:0]  opt_data;
  } fspa_cmd_s;
endpackage

/* verilog/fspa_sector_map.sv */
`timescale 1ns/1ps
`include "fspa_cfg.svh"
module fspa_sector_map
  import fspa_pkg::*;
#(
  parameter logic [16:0] FLASH_BYTES = 17'h0F000
) (
  input  wire logic [15:0] i_addr,
  output logic             o_valid,
  output logic [1:0]       o_sector
);
  logic [16:0] base_lo;
  assign base_lo = 17'h10000 - FLASH_BYTES;
  always_comb begin
    o_sector = 2'h2;
    if (i_addr >= `FSPA_SEC0_BASE) begin
      o_sector = 2'h0;
    end else if (i_addr >= `FSPA_SEC1_BASE) begin
      o_sector = 2'h1;
    end
    o_valid = ({1'b0, i_addr} >= base_lo);
  end
endmodule

/* test/fspa_tool_model.sv */
`timescale 1ns/1ps
module fspa_tool_model
  import fspa_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_attach,
  input  wire fspa_mode_e i_mode_req,
  output logic            o_srst,
  output fspa_mode_e      o_mode,
  output logic            o_attached,
  output logic            o_sdata_o,
  output logic            o_sdata_oe
);
  // The tool alone drives reset; the board circuit never adds one.
  assign o_srst = i_srst;
  always_ff @(posedge i_clk) begin
    o_attached <= i_attach;
    if (i_srst) begin
      o_mode     <= FSPA_MODE_APP;
      o_sdata_o  <= 1'b0;
      o_sdata_oe <= 1'b0;
    end else begin
      o_mode     <= (i_attach || i_mode_req < FSPA_MODE_INCIRCUIT_PROGRAMMING) ?
                    i_mode_req : FSPA_MODE_APP;
      o_sdata_oe <= i_attach;
      // A released data line keeps changing so no stale value is read.
      o_sdata_o  <= ~o_sdata_o;
    end
  end
endmodule

/* test/fspa_top_tb.sv */
`timescale 1ns/1ps
module fspa_top_tb;
  import fspa_pkg::*;
  logic       clk, srst_req, srst, attach, req_valid, rd_valid, tool_att, lk_o, lk_oe;
  logic       cmd_valid, rejected, rdv_o, rop, busy, taken, sclk, sdo, sdoe, cv, rj, bz;
  fspa_mode_e mode_req, mode;
  fspa_req_s  req;
  fspa_cmd_s  cmd, cq;
  logic [7:0] option, rd_data, rdd_o;
  int         mismatches, checks_done, cycles;
  fspa_tool_model u_tool (.i_clk(clk), .i_srst(srst_req), .i_attach(attach),
    .i_mode_req(mode_req), .o_srst(srst), .o_mode(mode), .o_attached(tool_att),
    .o_sdata_o(lk_o), .o_sdata_oe(lk_oe));
  fspa_top u_dut (.i_clk(clk), .i_srst(srst), .i_mode(mode), .i_tool_attached(tool_att),
    .i_req_valid(req_valid), .i_req(req), .i_option(option), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .i_app_sclk_o(1'b1), .i_app_sdata_o(1'b1), .i_app_sdata_oe(1'b1),
    .i_link_sdata_o(lk_o), .i_link_sdata_oe(lk_oe), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_rejected(rejected), .o_rd_valid(rdv_o), .o_rd_data(rdd_o), .o_readout_protect(rop),
    .o_auto_erase_busy(busy), .o_pins_taken(taken), .o_sclk_o(sclk), .o_sdata_o(sdo),
    .o_sdata_oe(sdoe));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input fspa_op_e op, input logic [15:0] a, input logic [7:0] d,
                      input logic o);
    req = '{op, a, d, o};
    req_valid = 1'b1;
    step(1);
    req_valid = 1'b0;
    cv = cmd_valid;
    rj = rejected;
    cq = cmd;
    bz = busy;
    step(1);
  endtask
  task automatic s_app_prog();
    mode_req = FSPA_MODE_IN_APPLICATION_PROGRAMMING;
    rd_valid = 1'b1;
    rd_data = 8'hA5;
    step(2);
    chk("app_pins", {taken, sclk, sdo, sdoe}, 4'h7);
    chk("rd_open", {rdv_o, rdd_o}, 9'h1A5);
    rd_valid = 1'b0;
    send(FSPA_OP_PROG, 16'hF000, 8'h5A, 1'b0);
    chk("app_sec0", {cv, rj}, 2'h1);
    send(FSPA_OP_PROG, 16'hE123, 8'h5A, 1'b0);
    chk("app_prog", {cv, cq.we, cq.addr, cq.data}, {2'h3, 16'hE123, 8'h5A});
  endtask
  task automatic s_tool();
    logic [15:0] base [3] = '{16'hF000, 16'hE000, 16'hD000};
    attach = 1'b1;
    mode_req = FSPA_MODE_TOOL;
    step(2);
    chk("pins", {taken, sclk, sdoe}, 3'h5);
    chk("link", sdo ^ lk_o, 1'b1);
    for (int i = 0; i < 3; i++) begin
      send(FSPA_OP_SECT_ERASE, base[i] + 16'h0FFF, 8'h00, 1'b0);
      chk("sect", {cv, cq.erase, cq.sector}, {2'h3, i[1:0]});
    end
    send(FSPA_OP_SECT_ERASE, 16'h0FFF, 8'h00, 1'b0);
    chk("below", {cv, rj}, 2'h1);
    send(FSPA_OP_PROG, 16'h1000, 8'h33, 1'b0);
    chk("lowest", {cv, cq.we, cq.sector}, 4'hE);
    send(FSPA_OP_MASS_ERASE, 16'h0000, 8'h00, 1'b0);
    chk("mass", {cv, cq.mass}, 2'h3);
    send(FSPA_OP_PROG, 16'h0000, 8'h80, 1'b1);
    chk("opt", {cv, cq.opt_we, cq.opt_data}, {2'h3, 8'h80});
  endtask
  task automatic s_rop();
    option = 8'h01;
    step(2);
    chk("rop", rop, 1'b1);
    rd_valid = 1'b1;
    rd_data = 8'hA5;
    step(1);
    rd_valid = 1'b0;
    chk("rd", {rdv_o, rdd_o}, 9'h100);
    send(FSPA_OP_PROG, 16'hD000, 8'h11, 1'b0);
    chk("rop_wr", {cv, rj}, 2'h1);
    req = '{FSPA_OP_PROG, 16'h0000, 8'hFE, 1'b1};
    req_valid = 1'b1;
    step(1);
    chk("busy", busy, 1'b1);
    // The request is held one more edge so that it meets the erase sweep and is refused.
    for (int i = 0; i < 3; i++) begin
      step(1);
      req_valid = 1'b0;
      chk("auto", {cmd_valid, cmd.erase, cmd.sector, cmd.mass, cmd.opt_we, busy, rejected},
          {2'h3, i[1:0], i == 2, i == 2, i != 2, i == 0});
    end
    chk("auto_opt", cmd.opt_data, 8'hFE);
    option = 8'h00;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    {srst_req, attach, req_valid, rd_valid} = 4'h8;
    mode_req = FSPA_MODE_APP;
    req = '0;
    option = 8'h00;
    rd_data = 8'h00;
    step(2);
    srst_req = 1'b0;
    chk("reset", {cmd_valid, rejected, rdv_o, rop, busy, taken, sdoe}, 7'h00);
    s_app_prog();
    s_tool();
    s_rop();
    stop_test();
  end
endmodule
